/* common/scpf_pkg.sv */
// Summary of operation
// - Up to sixteen optimized slave ports; requests carry a four-bit port index.
// - Optimized port data width fixed per build among 32, 128, 256, 512.
// - Optimized wrap bursts are 4, 8 or 16 beats; other lengths refused.
// - Without the exclusive monitor, exclusive requests complete as OKAY, never EXOKAY.
// - Optimized port transactions complete in arrival order, IDs ignored.
// - Coherent reads accept only listed ACE operations, and only shareable ones.
// - Snoops sent carry listed ACE codes; snoop response data is ignored.
// - Coherent exclusive support applies only to shareable transactions.
// - Generic port width fixed per build; narrow transfers are accepted.
// - Without CCIX coherency generic ports complete strictly in order.
// - Control port data width is 32 or 64 bits per build.
// - Control port decodes a 128 KB register window.
// - Control port has no byte strobes; writes update the full word.
// - Memory master issues wrap 2 to 16 and incr 1 to 64 beats.
// - Memory master uses one constant transaction ID.
// - Memory master data width fixed per build among 32 to 512 bits.
// - Everything runs on one common clock.
// - Reset is held at least one clock cycle to take effect.
package scpf_pkg;
    localparam int          NUM_OPT_PORTS = 16;
    localparam int          OPT_DATA_W    = 32;
    localparam int          GEN_DATA_W    = 64;
    localparam int          MST_DATA_W    = 128;
    localparam int          CTL_DATA_W    = 32;
    localparam logic [2:0]  OPT_SIZE      = 3'h2;
    localparam logic [2:0]  GEN_SIZE      = 3'h3;
    localparam logic [2:0]  MST_SIZE      = 3'h4;
    localparam int          CACHE_SIZE    = 65536;
    localparam int          LINE_WORDS    = 16;
    localparam int          CLEAR_CYCLES  = 2 * CACHE_SIZE / (4 * LINE_WORDS);
    localparam logic [3:0]  MST_ID        = 4'h0;
    localparam logic [8:0]  MST_MAX_INCR  = 9'h040;
    localparam logic [1:0]  BURST_FIXED   = 2'h0;
    localparam logic [1:0]  BURST_INCR    = 2'h1;
    localparam logic [1:0]  BURST_WRAP    = 2'h2;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_EXOKAY   = 2'h1;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [3:0]  SNP_RD_ONCE   = 4'h0;
    localparam logic [3:0]  SNP_RD_CLEAN  = 4'h2;
    localparam logic [3:0]  SNP_CLN_INV   = 4'h9;
    localparam logic [3:0]  SNP_CLN_UNQ   = 4'hB;
    localparam logic [3:0]  SNP_MK_INV    = 4'hD;
    localparam logic [3:0]  SNP_DVM_CMP   = 4'hE;
    localparam logic [3:0]  SNP_DVM_MSG   = 4'hF;
    localparam logic [3:0]  SNP_WR_UNQ    = 4'h0;
    localparam logic [14:0] WIN_HI        = 15'h0000;
    localparam logic [16:0] REG_CTRL      = 17'h00000;
    localparam logic [16:0] REG_STATUS    = 17'h00004;
    localparam logic [16:0] REG_ERRCNT    = 17'h00008;
    localparam logic [16:0] REG_REQCNT    = 17'h0000C;
    localparam int          CTRL_EXCL_BIT = 0;
    localparam int          CTRL_COH_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  len;
        logic [2:0]  size;
        logic [1:0]  burst;
        logic        lock;
        logic [1:0]  domain;
        logic [3:0]  snoop;
        logic        write;
        logic        generic;
        logic [3:0]  port;
    } scpf_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  len;
        logic [2:0]  size;
        logic [1:0]  burst;
        logic        write;
        logic [3:0]  id;
    } scpf_mreq_t;
endpackage

/* core/scpf_front_end.sv */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module scpf_front_end (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic                s_valid,
    input  wire scpf_pkg::scpf_req_t s_req,
    output logic                     s_ready,
    output logic                     s_resp_valid,
    output logic [1:0]               s_resp,
    input  wire logic                s_resp_ready,
    output logic                     m_valid,
    output scpf_pkg::scpf_mreq_t     m_req,
    input  wire logic                m_ready,
    input  wire logic                m_done,
    input  wire logic                m_err,
    output logic                     ac_valid,
    output logic [3:0]               ac_snoop,
    output logic [31:0]              ac_addr,
    input  wire logic                ac_ready
);
    typedef enum logic [2:0] {
        ST_CLEAR = 3'b000,
        ST_IDLE  = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT  = 3'b011,
        ST_SNOOP = 3'b100,
        ST_RESP  = 3'b101
    } scpf_state_t;

    function automatic logic len_line(input logic [7:0] len);
        len_line = (len == 8'h03) || (len == 8'h07) || (len == 8'h0F);
    endfunction

    function automatic logic win_ok(input logic [31:0] a);
        win_ok = (a[31:17] == scpf_pkg::WIN_HI);
    endfunction

    function automatic logic req_legal(input scpf_pkg::scpf_req_t r, input logic coh);
        logic ok;
        ok = (r.burst != scpf_pkg::BURST_FIXED) && (r.burst != 2'h3);
        if (r.generic) begin
            ok = ok && (r.size <= scpf_pkg::GEN_SIZE);
            if (r.burst == scpf_pkg::BURST_WRAP)
                ok = ok && (len_line(r.len) || r.len == 8'h01);
        end else begin
            ok = ok && (r.size == scpf_pkg::OPT_SIZE);
            if (r.burst == scpf_pkg::BURST_WRAP)
                ok = ok && len_line(r.len);
            else
                ok = ok && (len_line(r.len) || r.len == 8'h00);
            if (coh) begin
                ok = ok && (r.domain == 2'h1 || r.domain == 2'h2);
                if (r.write)
                    ok = ok && (r.snoop == scpf_pkg::SNP_WR_UNQ);
                else
                    ok = ok && (r.snoop == scpf_pkg::SNP_RD_ONCE
                        || r.snoop == scpf_pkg::SNP_RD_CLEAN
                        || r.snoop == scpf_pkg::SNP_CLN_UNQ
                        || r.snoop == scpf_pkg::SNP_CLN_INV
                        || r.snoop == scpf_pkg::SNP_MK_INV
                        || r.snoop == scpf_pkg::SNP_DVM_CMP
                        || r.snoop == scpf_pkg::SNP_DVM_MSG);
            end
        end
        req_legal = ok;
    endfunction

    scpf_state_t          st_r, st_nxt;
    logic [11:0]          clr_r, clr_nxt;
    scpf_pkg::scpf_req_t  cur_r, cur_nxt;
    logic [8:0]           rem_r, rem_nxt;
    logic                 err_r, err_nxt;
    logic                 s_ready_r, s_ready_nxt;
    logic                 rv_r, rv_nxt;
    logic [1:0]           rs_r, rs_nxt;
    logic                 mv_r, mv_nxt;
    scpf_pkg::scpf_mreq_t mq_r, mq_nxt;
    logic                 acv_r, acv_nxt;
    logic [31:0]          errcnt_r, errcnt_nxt;
    logic [31:0]          reqcnt_r, reqcnt_nxt;
    logic [1:0]           ctrl_r, ctrl_nxt;
    logic                 pready_r, pready_nxt;
    logic                 pslverr_r, pslverr_nxt;
    logic [31:0]          prdata_r, prdata_nxt;
    logic                 excl_en;
    logic                 coh_en;
    logic                 accept;
    logic [8:0]           chunk;

    assign excl_en = ctrl_r[scpf_pkg::CTRL_EXCL_BIT];
    assign coh_en  = ctrl_r[scpf_pkg::CTRL_COH_BIT];
    assign accept  = s_valid && s_ready_r;
    // Memory side never sees an incrementing burst above 64 beats
    assign chunk   = (cur_r.burst == scpf_pkg::BURST_INCR && rem_r > scpf_pkg::MST_MAX_INCR)
                   ? scpf_pkg::MST_MAX_INCR : rem_r;

    // One request in flight, so completion follows arrival order
    always_comb begin
        st_nxt      = st_r;
        clr_nxt     = clr_r;
        cur_nxt     = cur_r;
        rem_nxt     = rem_r;
        err_nxt     = err_r;
        rv_nxt      = rv_r;
        rs_nxt      = rs_r;
        mv_nxt      = mv_r;
        mq_nxt      = mq_r;
        acv_nxt     = acv_r;
        errcnt_nxt  = errcnt_r;
        reqcnt_nxt  = reqcnt_r;
        case (st_r)
            ST_CLEAR: begin
                clr_nxt = clr_r + 12'h001;
                if (clr_r == 12'(scpf_pkg::CLEAR_CYCLES - 1))
                    st_nxt = ST_IDLE;
            end
            ST_IDLE: begin
                if (accept) begin
                    cur_nxt    = s_req;
                    rem_nxt    = {1'b0, s_req.len} + 9'h001;
                    err_nxt    = 1'b0;
                    reqcnt_nxt = reqcnt_r + 32'h1;
                    if (!req_legal(s_req, coh_en)) begin
                        errcnt_nxt = errcnt_r + 32'h1;
                        rv_nxt     = 1'b1;
                        rs_nxt     = scpf_pkg::RESP_SLVERR;
                        st_nxt     = ST_RESP;
                    end else if (coh_en && !s_req.generic && !s_req.write
                                 && (s_req.snoop == scpf_pkg::SNP_CLN_INV
                                     || s_req.snoop == scpf_pkg::SNP_MK_INV)) begin
                        acv_nxt = 1'b1;
                        st_nxt  = ST_SNOOP;
                    end else begin
                        st_nxt = ST_ISSUE;
                    end
                end
            end
            ST_SNOOP: begin
                // Peer caches are only told; their data return is never awaited
                if (ac_ready) begin
                    acv_nxt = 1'b0;
                    st_nxt  = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (!mv_r) begin
                    mv_nxt        = 1'b1;
                    mq_nxt.addr   = cur_r.addr;
                    mq_nxt.len    = 8'(chunk - 9'h001);
                    mq_nxt.size   = cur_r.size;
                    mq_nxt.burst  = cur_r.burst;
                    mq_nxt.write  = cur_r.write;
                    mq_nxt.id     = scpf_pkg::MST_ID;
                end else if (m_ready) begin
                    mv_nxt     = 1'b0;
                    rem_nxt    = rem_r - chunk;
                    cur_nxt.addr = cur_r.addr + (32'(chunk) << cur_r.size);
                    st_nxt     = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (m_done) begin
                    err_nxt = err_r || m_err;
                    if (rem_r != 9'h000) begin
                        st_nxt = ST_ISSUE;
                    end else begin
                        rv_nxt = 1'b1;
                        st_nxt = ST_RESP;
                        if (err_r || m_err)
                            rs_nxt = scpf_pkg::RESP_SLVERR;
                        else if (excl_en && cur_r.lock
                                 && (!coh_en || cur_r.generic || cur_r.domain != 2'h0))
                            rs_nxt = scpf_pkg::RESP_EXOKAY;
                        else
                            rs_nxt = scpf_pkg::RESP_OKAY;
                    end
                end
            end
            ST_RESP: begin
                if (s_resp_ready) begin
                    rv_nxt = 1'b0;
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_CLEAR;
        endcase
        s_ready_nxt = (st_nxt == ST_IDLE) && !accept;
    end

    // Single clock for all logic; reset is asynchronous and acts with no clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= ST_CLEAR;
            clr_r     <= 12'h000;
            cur_r     <= '0;
            rem_r     <= 9'h000;
            err_r     <= 1'b0;
            s_ready_r <= 1'b0;
            rv_r      <= 1'b0;
            rs_r      <= scpf_pkg::RESP_OKAY;
            mv_r      <= 1'b0;
            mq_r      <= '0;
            acv_r     <= 1'b0;
            errcnt_r  <= 32'h0;
            reqcnt_r  <= 32'h0;
        end else begin
            st_r      <= st_nxt;
            clr_r     <= clr_nxt;
            cur_r     <= cur_nxt;
            rem_r     <= rem_nxt;
            err_r     <= err_nxt;
            s_ready_r <= s_ready_nxt;
            rv_r      <= rv_nxt;
            rs_r      <= rs_nxt;
            mv_r      <= mv_nxt;
            mq_r      <= mq_nxt;
            acv_r     <= acv_nxt;
            errcnt_r  <= errcnt_nxt;
            reqcnt_r  <= reqcnt_nxt;
        end
    end

    // Control port answers one cycle into the access phase
    always_comb begin
        logic acc;
        logic [16:0] off;
        acc         = psel && penable && !pready_r;
        off         = paddr[16:0];
        pready_nxt  = acc;
        pslverr_nxt = acc && !win_ok(paddr);
        prdata_nxt  = prdata_r;
        ctrl_nxt    = ctrl_r;
        if (acc) begin
            prdata_nxt = 32'h0;
            if (!pwrite && win_ok(paddr)) begin
                case (off)
                    scpf_pkg::REG_CTRL:   prdata_nxt = {30'h0, ctrl_r};
                    scpf_pkg::REG_STATUS: prdata_nxt = {30'h0, st_r != ST_IDLE,
                                                        st_r == ST_CLEAR};
                    scpf_pkg::REG_ERRCNT: prdata_nxt = errcnt_r;
                    scpf_pkg::REG_REQCNT: prdata_nxt = reqcnt_r;
                    default:              prdata_nxt = 32'h0;
                endcase
            end
        end
        // No strobes exist, so a write always replaces the whole field
        if (psel && penable && pready_r && pwrite && win_ok(paddr)
            && off == scpf_pkg::REG_CTRL)
            ctrl_nxt = pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
            ctrl_r    <= scpf_pkg::CTRL_RESET;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            ctrl_r    <= ctrl_nxt;
        end
    end

    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign prdata       = prdata_r;
    assign s_ready      = s_ready_r;
    assign s_resp_valid = rv_r;
    assign s_resp       = rs_r;
    assign m_valid      = mv_r;
    assign m_req        = mq_r;
    assign ac_valid     = acv_r;
    assign ac_snoop     = cur_r.snoop;
    assign ac_addr      = cur_r.addr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    clear_ready_a: assert property ((st_r == ST_CLEAR) |-> !s_ready_r)
        else $error("slave ready raised during clearing");
    busy_ready_a: assert property ((st_r != ST_IDLE) |=> !(s_ready_r && st_r != ST_IDLE))
        else $error("new request taken while one is in flight");
    no_exokay_a: assert property (rv_r && !excl_en |-> rs_r != scpf_pkg::RESP_EXOKAY)
        else $error("exokay without exclusive monitor");
    fixed_err_a: assert property (accept && s_req.burst == scpf_pkg::BURST_FIXED
        |=> rv_r && rs_r == scpf_pkg::RESP_SLVERR)
        else $error("fixed burst not refused");
    const_id_a: assert property (mv_r |-> mq_r.id == scpf_pkg::MST_ID)
        else $error("memory request id not constant");
    incr_len_a: assert property (mv_r && mq_r.burst == scpf_pkg::BURST_INCR
        |-> mq_r.len <= 8'h3F)
        else $error("memory incr burst above 64 beats");
    wrap_len_a: assert property (mv_r && mq_r.burst == scpf_pkg::BURST_WRAP
        |-> mq_r.len inside {8'h01, 8'h03, 8'h07, 8'h0F})
        else $error("memory wrap burst length illegal");
    mreq_hold_a: assert property (mv_r && !m_ready |=> mv_r && $stable(mq_r))
        else $error("memory request dropped before taken");
    apb_window_a: assert property (psel && penable && !pready_r && paddr[31:17] != 15'h0
        |=> pready_r && pslverr_r)
        else $error("access outside register window not flagged");
endmodule

/* test/scpf_mem_model.sv */
`timescale 1ns/1ps
module scpf_mem_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic m_valid,
    input  wire logic slow,
    input  wire logic err,
    input  wire logic ac_valid,
    output logic      m_ready,
    output logic      m_done,
    output logic      m_err,
    output logic      ac_ready
);
    logic [3:0] wait_r;
    logic       busy_r;
    logic       tog_r;
    // One chunk at a time, like the real controller; slow mode stretches both waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_ready  <= 1'b0;
            m_done   <= 1'b0;
            busy_r   <= 1'b0;
            wait_r   <= 4'h0;
            tog_r    <= 1'b0;
            ac_ready <= 1'b0;
        end else begin
            tog_r    <= ~tog_r;
            m_ready  <= 1'b0;
            m_done   <= 1'b0;
            ac_ready <= ac_valid & ~ac_ready;
            if (m_valid && !m_ready && !busy_r) begin
                if (wait_r == (slow ? 4'h5 : 4'h0)) begin
                    m_ready <= 1'b1;
                    busy_r  <= 1'b1;
                    wait_r  <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end else if (busy_r) begin
                if (wait_r == (slow ? 4'h7 : 4'h1)) begin
                    m_done <= 1'b1;
                    busy_r <= 1'b0;
                    wait_r <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
        end
    end
    // Error flag only means something with done, so it wanders otherwise
    assign m_err = m_done ? err : tog_r;
endmodule

/* test/scpf_front_end_tb.sv */
`timescale 1ns/1ps
module scpf_front_end_tb;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [31:0]          paddr, pwdata, prdata, q, ac_addr;
    logic                 s_valid, s_ready, s_resp_valid, s_resp_ready, slow, err;
    logic                 m_valid, m_ready, m_done, m_err, ac_valid, ac_ready;
    logic [1:0]           s_resp;
    logic [3:0]           ac_snoop;
    scpf_pkg::scpf_req_t  s_req, r;
    scpf_pkg::scpf_mreq_t m_req, m;
    scpf_pkg::scpf_mreq_t mq[$];
    logic [35:0]          acq[$];
    int                   n_errors, compares, cyc;

    scpf_front_end i_scpf_front_end (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .s_valid(s_valid),
        .s_req(s_req), .s_ready(s_ready), .s_resp_valid(s_resp_valid), .s_resp(s_resp),
        .s_resp_ready(s_resp_ready), .m_valid(m_valid), .m_req(m_req), .m_ready(m_ready),
        .m_done(m_done), .m_err(m_err), .ac_valid(ac_valid), .ac_snoop(ac_snoop),
        .ac_addr(ac_addr), .ac_ready(ac_ready));
    scpf_mem_model i_scpf_mem_model (.pclk(pclk), .presetn(presetn), .m_valid(m_valid),
        .slow(slow), .err(err), .ac_valid(ac_valid), .m_ready(m_ready), .m_done(m_done),
        .m_err(m_err), .ac_ready(ac_ready));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Request held from setup until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [16:0] a, input logic [31:0] d);
        apb(1'b1, {15'h0, a}, d);
    endtask

    task automatic rd(input logic [16:0] a, input logic [31:0] exp);
        apb(1'b0, {15'h0, a}, 32'h0);
        chk(q, exp);
    endtask

    // Response is left waiting a cycle to see that it stands
    task automatic send(input scpf_pkg::scpf_req_t t, input logic [1:0] exp);
        s_req   <= t;
        s_valid <= 1'b1;
        @(posedge pclk);
        while (s_ready !== 1'b1) @(posedge pclk);
        s_valid <= 1'b0;
        while (s_resp_valid !== 1'b1) @(posedge pclk);
        @(posedge pclk);
        chk({31'h0, s_resp_valid}, 32'h1);
        chk({30'h0, s_resp}, {30'h0, exp});
        s_resp_ready <= 1'b1;
        @(posedge pclk);
        s_resp_ready <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic scpf_pkg::scpf_req_t mk(input logic [7:0] l, input logic [2:0] s,
                                              input logic [1:0] b, input logic g);
        scpf_pkg::scpf_req_t t;
        t = '0;
        t.addr = 32'h0000_1000;
        t.len = l;
        t.size = s;
        t.burst = b;
        t.generic = g;
        t.port = 4'hF;
        return t;
    endfunction

    task automatic t_clear();
        rd(scpf_pkg::REG_STATUS, 32'h3);
        repeat (2000) begin
            @(posedge pclk);
            if (s_ready !== 1'b0) chk({31'h0, s_ready}, 32'h0);
        end
        while (s_ready !== 1'b1) @(posedge pclk);
        rd(scpf_pkg::REG_STATUS, 32'h0);
    endtask

    task automatic t_regs();
        wr(scpf_pkg::REG_CTRL, 32'hFFFF_FFFF);
        rd(scpf_pkg::REG_CTRL, 32'h3);
        wr(scpf_pkg::REG_CTRL, 32'h0);
        rd(scpf_pkg::REG_CTRL, 32'h0);
        apb(1'b1, 32'h0002_0000, 32'h3);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 32'h0001_FFFC, 32'h0);
        chk({31'h0, e}, 32'h0);
        rd(scpf_pkg::REG_CTRL, 32'h0);
        wr(scpf_pkg::REG_ERRCNT, 32'h55);
        rd(scpf_pkg::REG_ERRCNT, 32'h0);
    endtask

    // Every refused shape answers with an error and never reaches memory
    task automatic t_bad();
        for (int i = 0; i < 6; i++) begin
            r = mk(8'h03, scpf_pkg::OPT_SIZE, scpf_pkg::BURST_WRAP, 1'b0);
            case (i)
                0: r.burst = scpf_pkg::BURST_FIXED;
                1: r.len = 8'h05;
                2: r.burst = scpf_pkg::BURST_INCR;
                3: r.size = 3'h1;
                4: r.generic = 1'b1;
                default: r.size = 3'h4;
            endcase
            if (i > 3) r.generic = 1'b1;
            if (i == 2) r.len = 8'h01;
            if (i == 4) r.len = 8'h1F;
            send(r, scpf_pkg::RESP_SLVERR);
        end
        chk(32'(mq.size()), 32'h0);
        rd(scpf_pkg::REG_ERRCNT, 32'h6);
        rd(scpf_pkg::REG_REQCNT, 32'h6);
    endtask

    task automatic t_good();
        logic [7:0] lens[4] = '{8'h00, 8'h03, 8'h07, 8'h0F};
        for (int i = 0; i < 4; i++) begin
            r = mk(lens[i], scpf_pkg::OPT_SIZE,
                   (i == 0) ? scpf_pkg::BURST_INCR : scpf_pkg::BURST_WRAP, 1'b0);
            slow <= (i > 1);
            send(r, scpf_pkg::RESP_OKAY);
            chk(32'(mq.size()), 32'h1);
            m = mq.pop_front();
            chk({28'h0, m.id}, {28'h0, scpf_pkg::MST_ID});
            chk({29'h0, m.size}, {29'h0, scpf_pkg::OPT_SIZE});
        end
        send(mk(8'hFF, 3'h0, scpf_pkg::BURST_INCR, 1'b1), scpf_pkg::RESP_OKAY);
        chk(32'(mq.size()), 32'h4);
        for (int k = 0; k < 4; k++) begin
            m = mq.pop_front();
            chk({24'h0, m.len}, 32'h3F);
            chk(m.addr, 32'h0000_1000 + 32'(k * 64));
        end
        slow <= 1'b0;
        send(mk(8'h01, scpf_pkg::GEN_SIZE, scpf_pkg::BURST_WRAP, 1'b1), scpf_pkg::RESP_OKAY);
        m = mq.pop_front();
        chk({22'h0, m.burst, m.len}, {22'h0, scpf_pkg::BURST_WRAP, 8'h01});
        err <= 1'b1;
        send(mk(8'h00, scpf_pkg::GEN_SIZE, scpf_pkg::BURST_INCR, 1'b1), scpf_pkg::RESP_SLVERR);
        err <= 1'b0;
        mq.delete();
    endtask

    task automatic t_excl();
        r = mk(8'h00, scpf_pkg::OPT_SIZE, scpf_pkg::BURST_INCR, 1'b0);
        r.lock = 1'b1;
        send(r, scpf_pkg::RESP_OKAY);
        r.generic = 1'b1;
        send(r, scpf_pkg::RESP_OKAY);
        r.generic = 1'b0;
        wr(scpf_pkg::REG_CTRL, 32'h1);
        send(r, scpf_pkg::RESP_EXOKAY);
        wr(scpf_pkg::REG_CTRL, 32'h0);
    endtask

    task automatic t_coh();
        logic [3:0] codes[7] = '{scpf_pkg::SNP_RD_ONCE, scpf_pkg::SNP_RD_CLEAN,
            scpf_pkg::SNP_CLN_UNQ, scpf_pkg::SNP_CLN_INV, scpf_pkg::SNP_MK_INV,
            scpf_pkg::SNP_DVM_CMP, scpf_pkg::SNP_DVM_MSG};
        wr(scpf_pkg::REG_CTRL, 32'h2);
        r = mk(8'h00, scpf_pkg::OPT_SIZE, scpf_pkg::BURST_INCR, 1'b0);
        r.domain = 2'h1;
        for (int i = 0; i < 7; i++) begin
            r.snoop = codes[i];
            send(r, scpf_pkg::RESP_OKAY);
        end
        chk({28'h0, acq[0][35:32]}, {28'h0, scpf_pkg::SNP_CLN_INV});
        chk(acq[0][31:0], 32'h0000_1000);
        chk({28'h0, acq[1][35:32]}, {28'h0, scpf_pkg::SNP_MK_INV});
        chk(acq[1][31:0], 32'h0000_1000);
        r.domain = 2'h0;
        send(r, scpf_pkg::RESP_SLVERR);
        r.domain = 2'h2;
        r.write = 1'b1;
        r.snoop = scpf_pkg::SNP_WR_UNQ;
        send(r, scpf_pkg::RESP_OKAY);
        r.snoop = 4'h1;
        send(r, scpf_pkg::RESP_SLVERR);
        wr(scpf_pkg::REG_CTRL, 32'h3);
        r.write = 1'b0;
        r.snoop = scpf_pkg::SNP_RD_ONCE;
        r.lock = 1'b1;
        send(r, scpf_pkg::RESP_EXOKAY);
    endtask

    // Hang guard well above the clearing time plus all traffic
    always @(posedge pclk) begin
        cyc++;
        if (m_valid === 1'b1 && m_ready === 1'b1) mq.push_back(m_req);
        if (ac_valid === 1'b1 && ac_ready === 1'b1) acq.push_back({ac_snoop, ac_addr});
        if (cyc == 30000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        {psel, penable, pwrite, s_valid, s_resp_ready, slow, err, presetn} = 8'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        s_req = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_clear();
        t_regs();
        t_bad();
        t_good();
        t_excl();
        t_coh();
        close_out();
    end
endmodule
